/* bsp_pkg.sv */
/*
  Constants shared by the two-word burst SRAM port: data lane layout,
  power-on lock and impedance refresh timing, and the power-on states.
  Assumes the core clock runs at the rate given by CLK_PERIOD_NS.
*/
package bsp_pkg;

  // ==========================================================
  // Data organisation
  // ==========================================================
  localparam int LANE_W = 9;        // Bits per byte lane
  localparam int DATA_W_DFLT = 36;  // Widest organisation
  localparam int ADDR_W_DFLT = 4;   // Small model depth by default

  // ==========================================================
  // Timing on the core clock
  // ==========================================================
  localparam int CLK_PERIOD_NS = 5;     // 200 MHz core clock
  localparam int LOCK_TIME_US = 20;     // Stable clock before use
  localparam int IMP_PERIOD_US = 20;    // Impedance refresh interval
  // More than the lock time: round up, then one cycle beyond
  localparam int LOCK_CYC =
    (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // Periodic refresh: a longest time, rounded down
  localparam int IMP_CYC = (IMP_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int STRAP_CYC = 3;         // Wait out pin synchroniser
  localparam int CNT_W = 13;            // Holds every count above
  localparam int SYNC_STAGES = 2;       // Flops per crossing

  // ==========================================================
  // Power-on sequence states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,  // Catch the termination strap
    ST_LOCK = 3'b010,   // Let the delay loop settle
    ST_RUN = 3'b100     // Normal operation
  } bsp_state_t;

endpackage : bsp_pkg

/* bsp_sync.sv */
/*
  Multi-bit level synchroniser: each bit passes a chain of flops.
  Assumes the bits are independent levels that change slowly.
*/
`timescale 1ns/100ps
`default_nettype none

module bsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ==========================================================
  // Chain of flops
  // ==========================================================
  // First stage is read only by the second stage
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] hold_r;
  logic [W-1:0] hold_nxt;

  // Next values of the chain
  always_comb begin
    meta_nxt = d_i;
    hold_nxt = meta_r;
  end

  // Register the chain
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign q_o = hold_r;

endmodule : bsp_sync
`default_nettype wire

/* bsp_port.sv */
/*
  Device side of a two-word burst double-data-rate SRAM port with a
  shared data bus, echo clocks, read-valid flag and dynamic on-die
  termination, plus the power-on lock and impedance refresh timers.
  Assumes the controller drives K and its complement exactly opposite,
  so the complement rising edge is taken as the falling edge of K.
*/
// Behaviour
// - Every transfer moves exactly two words
// - Address sampled on K rise, ignored on NOP
// - Select high reads, low writes, at K
// - Data taken and launched on both edges
// - Data width 9, 18 or 36 bits
// - Active-low byte enables sampled per data edge
// - One enable per nine-bit lane
// - Echo clocks run free, matched to data
// - Read-valid flags read data, echo aligned
// - Impedance refreshed every 20 us
// - Termination strap latched before stable clock
// - Data termination off half cycle before read
// - Data termination on half cycle after read
// - Byte-enable termination always on when enabled
// - Read latency fixed at 2.0 or 2.5
// - Write data follows command by one cycle
// - Second word uses next burst address
`timescale 1ns/100ps
`default_nettype none

module bsp_port #(
  parameter int DATA_W = bsp_pkg::DATA_W_DFLT,  // 9, 18 or 36
  parameter int ADDR_W = bsp_pkg::ADDR_W_DFLT,  // Burst-pair address
  parameter bit RD_LAT25 = 1'b1,                // 1: 2.5, 0: 2.0 cycles
  parameter int BW_N = DATA_W / bsp_pkg::LANE_W
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic k_clk_i,
  input wire logic load_strobe_n_i,
  input wire logic rd_wr_sel_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [BW_N-1:0] byte_write_en_n_i,
  input wire logic [DATA_W-1:0] data_io_bus_i,
  output logic [DATA_W-1:0] data_io_bus_o,
  output logic data_io_bus_oe_o,
  output logic echo_clock_true_o,
  output logic echo_clock_comp_o,
  output logic read_valid_flag_o,
  input wire logic termination_ctrl_i,
  input wire logic loop_off_n_i,
  output logic dq_term_on_o,
  output logic bw_term_on_o,
  output logic loop_locked_o,
  output logic term_enabled_o,
  output logic imp_update_o
);

  // ==========================================================
  // Core-clock power-on sequence
  // ==========================================================
  logic [1:0] pin_s;                  // Synced strap and loop pin
  bsp_pkg::bsp_state_t st_r;          // Power-on state
  bsp_pkg::bsp_state_t st_nxt;
  logic [bsp_pkg::CNT_W-1:0] cnt_r;   // Shared lock/refresh counter
  logic [bsp_pkg::CNT_W-1:0] cnt_nxt;
  logic term_en_r;                    // Latched termination choice
  logic term_en_nxt;
  logic lock_r;                       // Loop ready for commands
  logic lock_nxt;
  logic imp_r;                        // Impedance refresh pulse
  logic imp_nxt;

  // Pins are asynchronous to the core clock
  bsp_sync #(.W(2)) u_pin_sync (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i({termination_ctrl_i, loop_off_n_i}),
    .q_o(pin_s)
  );

  // Next state of the sequence and its timers
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 1'b1;
    term_en_nxt = term_en_r;
    lock_nxt = lock_r;
    imp_nxt = 1'b0;
    unique case (st_r)
      bsp_pkg::ST_STRAP: begin
        // Strap caught once, before the clock counts as stable
        if (cnt_r == bsp_pkg::CNT_W'(bsp_pkg::STRAP_CYC - 1)) begin
          term_en_nxt = pin_s[1];
          st_nxt = bsp_pkg::ST_LOCK;
          cnt_nxt = '0;
        end
      end
      bsp_pkg::ST_LOCK: begin
        // Loop disabled low: no lock wait, timing not guaranteed
        if (!pin_s[0] ||
            cnt_r == bsp_pkg::CNT_W'(bsp_pkg::LOCK_CYC - 1)) begin
          st_nxt = bsp_pkg::ST_RUN;
          lock_nxt = 1'b1;
          cnt_nxt = '0;
        end
      end
      bsp_pkg::ST_RUN: begin
        // Periodic output impedance refresh
        if (cnt_r == bsp_pkg::CNT_W'(bsp_pkg::IMP_CYC - 1)) begin
          imp_nxt = 1'b1;
          cnt_nxt = '0;
        end
      end
      default: begin
        st_nxt = bsp_pkg::ST_STRAP;
        cnt_nxt = '0;
      end
    endcase
  end

  // Register the sequence
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= bsp_pkg::ST_STRAP;
      cnt_r <= '0;
      term_en_r <= 1'b0;
      lock_r <= 1'b0;
      imp_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      term_en_r <= term_en_nxt;
      lock_r <= lock_nxt;
      imp_r <= imp_nxt;
    end
  end

  assign loop_locked_o = lock_r;
  assign term_enabled_o = term_en_r;
  assign imp_update_o = imp_r;

  // ==========================================================
  // Link-clock rising-edge logic
  // ==========================================================
  logic [1:0] k_s;                // Synced {termination, lock}
  logic [DATA_W-1:0] mem [2**(ADDR_W+1)];  // Burst-pair storage
  logic cmd_rd_r, cmd_rd_nxt;     // Read loaded this cycle
  logic cmd_wr_r, cmd_wr_nxt;     // Write loaded this cycle
  logic rd1_r, rd2_r, rd3_r;      // Read age pipeline
  logic wr1_r;                    // Write one cycle old
  logic [ADDR_W-1:0] addr0_r, addr1_r, addr2_r;
  logic hi_drv_r, hi_drv_nxt;     // Drive during K high half
  logic hi_toff_r, hi_toff_nxt;   // Termination off, high half
  logic [DATA_W-1:0] hi_q_r, hi_q_nxt;
  logic ph_a_r;                   // Toggles every K rise
  logic bwt_r;                    // Byte-enable termination on
  logic wr0_en, wr1_en;           // Word commits this edge
  logic [DATA_W-1:0] wr0_dat, wr1_dat;

  // Lock and strap cross into the link domain as levels
  bsp_sync #(.W(2)) u_k_sync (
    .clk_i(k_clk_i),
    .nrst_i(nrst_i),
    .d_i({term_en_r, lock_r}),
    .q_o(k_s)
  );

  // Keep old lanes whose active-low enable is high
  function automatic logic [DATA_W-1:0] merge_lanes(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [BW_N-1:0] en_n
  );
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < BW_N; i++) begin
      if (!en_n[i]) begin
        res[i*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] =
          new_w[i*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
      end
    end
    return res;
  endfunction : merge_lanes

  // Negative-edge side, declared here for the commit path
  logic lo_wpend_r;               // Second write word waiting
  logic [ADDR_W-1:0] lo_wa_r;
  logic [DATA_W-1:0] lo_wd_r;
  logic [BW_N-1:0] lo_bw_r;
  logic lo_drv_r, lo_toff_r, ph_b_r;
  logic [DATA_W-1:0] lo_q_r;

  // Command decode, read launch and write commits
  always_comb begin
    // Address and select count only with the strobe low
    cmd_rd_nxt = k_s[0] && !load_strobe_n_i && rd_wr_sel_i;
    cmd_wr_nxt = k_s[0] && !load_strobe_n_i && !rd_wr_sel_i;
    hi_drv_nxt = RD_LAT25 ? rd2_r : rd1_r;
    hi_toff_nxt = rd1_r || rd2_r;
    // 2.0: first word of the burst; 2.5: second word
    hi_q_nxt = RD_LAT25 ? mem[{addr2_r, 1'b1}]
                        : mem[{addr1_r, 1'b0}];
    // First write word lands one cycle after its command
    wr0_en = cmd_wr_r;
    wr0_dat = merge_lanes(mem[{addr0_r, 1'b0}], data_io_bus_i,
                          byte_write_en_n_i);
    // Second word, taken on the falling edge, commits here
    wr1_en = lo_wpend_r;
    wr1_dat = merge_lanes(mem[{lo_wa_r, 1'b1}], lo_wd_r, lo_bw_r);
  end

  // Burst storage has no reset
  always_ff @(posedge k_clk_i) begin
    if (wr1_en) begin
      mem[{lo_wa_r, 1'b1}] <= wr1_dat;
    end
    if (wr0_en) begin
      mem[{addr0_r, 1'b0}] <= wr0_dat;
    end
  end

  // Register the rising-edge group
  always_ff @(posedge k_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_rd_r <= 1'b0;
      cmd_wr_r <= 1'b0;
      rd1_r <= 1'b0;
      rd2_r <= 1'b0;
      rd3_r <= 1'b0;
      wr1_r <= 1'b0;
      addr0_r <= '0;
      addr1_r <= '0;
      addr2_r <= '0;
      hi_drv_r <= 1'b0;
      hi_toff_r <= 1'b0;
      hi_q_r <= '0;
      ph_a_r <= 1'b0;
      bwt_r <= 1'b0;
    end else begin
      cmd_rd_r <= cmd_rd_nxt;
      cmd_wr_r <= cmd_wr_nxt;
      rd1_r <= cmd_rd_r;
      rd2_r <= rd1_r;
      rd3_r <= rd2_r;
      wr1_r <= cmd_wr_r;
      // NOP leaves the loaded address alone
      addr0_r <= load_strobe_n_i ? addr0_r : addr_i;
      addr1_r <= addr0_r;
      addr2_r <= addr1_r;
      hi_drv_r <= hi_drv_nxt;
      hi_toff_r <= hi_toff_nxt;
      hi_q_r <= hi_q_nxt;
      ph_a_r <= !ph_a_r;
      bwt_r <= k_s[1];
    end
  end

  // ==========================================================
  // Link-clock falling-edge logic (complement clock rise)
  // ==========================================================
  logic lo_drv_nxt, lo_toff_nxt;
  logic [DATA_W-1:0] lo_q_nxt;

  // Low-half drive, termination and read data word
  always_comb begin
    lo_drv_nxt = rd2_r;
    lo_toff_nxt = RD_LAT25 ? (rd2_r || rd3_r)
                           : (rd1_r || rd2_r);
    lo_q_nxt = RD_LAT25 ? mem[{addr2_r, 1'b0}]
                        : mem[{addr2_r, 1'b1}];
  end

  // Register the falling-edge group
  always_ff @(negedge k_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lo_wpend_r <= 1'b0;
      lo_wa_r <= '0;
      lo_wd_r <= '0;
      lo_bw_r <= '1;
      lo_drv_r <= 1'b0;
      lo_toff_r <= 1'b0;
      lo_q_r <= '0;
      ph_b_r <= 1'b0;
    end else begin
      lo_wpend_r <= wr1_r;
      lo_wa_r <= addr1_r;
      lo_wd_r <= data_io_bus_i;
      lo_bw_r <= byte_write_en_n_i;
      lo_drv_r <= lo_drv_nxt;
      lo_toff_r <= lo_toff_nxt;
      lo_q_r <= lo_q_nxt;
      // Copies the rise toggle, so the echo keeps its phase whichever
      // half of K the reset is released in
      ph_b_r <= ph_a_r;
    end
  end

  // ==========================================================
  // Pin outputs
  // ==========================================================
  // Each half of K shows the flop launched at its own edge; the
  // select is the clock itself, the cost of a true DDR pin
  assign data_io_bus_o = k_clk_i ? hi_q_r : lo_q_r;
  assign data_io_bus_oe_o = k_clk_i ? hi_drv_r : lo_drv_r;
  assign read_valid_flag_o = k_clk_i ? hi_drv_r : lo_drv_r;
  assign echo_clock_true_o = ph_a_r ^ ph_b_r;
  assign echo_clock_comp_o = !(ph_a_r ^ ph_b_r);
  assign dq_term_on_o = bwt_r && !(k_clk_i ? hi_toff_r : lo_toff_r);
  assign bw_term_on_o = bwt_r;

  // ==========================================================
  // Checks
  // ==========================================================
  a_nop_ignored: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    load_strobe_n_i |=> !cmd_rd_r && !cmd_wr_r && $stable(addr0_r))
    else $error("NOP loaded a command or address");

  a_read_latency: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    cmd_rd_nxt |-> ##3 lo_drv_r && (hi_drv_r || RD_LAT25) ##1
      (hi_drv_r || !RD_LAT25))
    else $error("Read data not driven at fixed latency");

  a_write_slot: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    cmd_wr_nxt |=> wr0_en ##1 wr1_en)
    else $error("Write words not committed one cycle on");

  a_bus_quiet: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    (!rd1_r && !rd2_r) |=> !hi_drv_r)
    else $error("Bus driven without a read");

  a_term_before: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    hi_drv_r |-> hi_toff_r && $past(lo_toff_r))
    else $error("Termination on while driving");

  a_bw_term: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    k_s[1] |=> bw_term_on_o [*2])
    else $error("Byte-enable termination dropped");

  a_echo_phase: assert property (
    @(posedge k_clk_i) disable iff (!nrst_i)
    ##1 !echo_clock_true_o && echo_clock_comp_o)
    else $error("Echo clock not low before K rise");

  a_imp_period: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    imp_r |=> (!imp_r) [*8])
    else $error("Impedance refresh too frequent");

  a_lock_wait: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(lock_r) |-> !$past(pin_s[0]) ||
      $past(cnt_r) == bsp_pkg::CNT_W'(bsp_pkg::LOCK_CYC - 1))
    else $error("Lock declared before the wait ended");

  a_strap_held: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (st_r != bsp_pkg::ST_STRAP) |=> $stable(term_en_r))
    else $error("Termination choice changed after power-on");

endmodule : bsp_port
`default_nettype wire

/* bsp_ctl_model.sv */
/*
  Memory controller model for the burst port: makes the link clock,
  issues one command at a time and drives the write data words.
  Assumes the bench resolves the shared data bus from both sides.
*/
`timescale 1ns/100ps
`default_nettype none

module bsp_ctl_model #(
  parameter int DW = 36,
  parameter int AW = 4,
  parameter int BN = 4
) (
  output logic k_clk_o,
  output logic load_strobe_n_o,
  output logic rd_wr_sel_o,
  output logic [AW-1:0] addr_o,
  output logic [BN-1:0] byte_write_en_n_o,
  output logic [DW-1:0] data_o
);
  // ==========================================================
  // Link clock
  // ==========================================================
  // Free running; the complement clock is simply its inverse
  initial begin
    k_clk_o = 1'b0;
    load_strobe_n_o = 1'b1;
    rd_wr_sel_o = 1'b0;
    addr_o = '0;
    byte_write_en_n_o = '1;
    data_o = '0;
    #1.7;
    // Steady and never stopped; this bench rate sits below the loop
    // floor, so loop timing here proves nothing about a real part
    forever #6 k_clk_o = ~k_clk_o;
  end

  // ==========================================================
  // Command issue
  // ==========================================================
  // Idle lines show the inverse so stale values are never trusted
  task automatic cmd(input logic rd, input logic [AW-1:0] a,
    input logic [DW-1:0] d0, input logic [DW-1:0] d1,
    input logic [BN-1:0] b0, input logic [BN-1:0] b1);
    @(posedge k_clk_o);
    load_strobe_n_o <= 1'b0;
    rd_wr_sel_o <= rd;
    addr_o <= a;
    @(posedge k_clk_o);
    load_strobe_n_o <= 1'b1;
    rd_wr_sel_o <= ~rd;
    addr_o <= ~a;
    if (rd) begin
      // Hostile idle enables: a NOP must still store nothing
      byte_write_en_n_o <= '0;
    end else begin
      // Word 0 stands until the K rise that takes it
      data_o <= d0;
      byte_write_en_n_o <= b0;
      @(posedge k_clk_o);
      // Word 1 launched at that rise, taken at the next fall
      data_o <= d1;
      byte_write_en_n_o <= b1;
      @(negedge k_clk_o);
      data_o <= ~d1;
      byte_write_en_n_o <= ~b1;
    end
  endtask : cmd
endmodule : bsp_ctl_model
`default_nettype wire

/* bsp_port_tb.sv */
/*
  Self-checking bench for the burst port: power-on, writes, masked
  writes, reads, echo clocks, impedance refresh and a second strap.
  Assumes default port parameters: 36 bits, 2.5 cycle read latency.
*/
`timescale 1ns/100ps
`default_nettype none

module bsp_port_tb;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam logic [35:0] A0 = 36'h123456789;
  localparam logic [35:0] A1 = 36'h9abcdef01;
  localparam logic [35:0] B0 = 36'h0f0f0f0f0;
  localparam logic [35:0] B1 = 36'hf0f0f0f0f;
  localparam logic [35:0] C0 = 36'h555555555;
  localparam logic [35:0] C1 = 36'haaaaaaaaa;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic strap = 1'b1;
  logic loop_off_n = 1'b1;
  logic k, lsn, rw, oe, ect, ecc, valid, dterm, bw_term;
  logic locked, te_o, imp_upd;
  logic [3:0] addr;
  logic [3:0] bwn;
  logic [35:0] md, dout, bus;
  int n_errors = 0;
  int cmp_count = 0;

  // Shared bus: the device wins while it drives
  assign bus = oe ? dout : md;

  always #2.5 ref_clk = ~ref_clk;

  bsp_ctl_model ctl_u (.k_clk_o(k), .load_strobe_n_o(lsn),
    .rd_wr_sel_o(rw), .addr_o(addr), .byte_write_en_n_o(bwn),
    .data_o(md));

  bsp_port dut_u (.ref_clk_i(ref_clk), .nrst_i(nrst), .k_clk_i(k),
    .load_strobe_n_i(lsn), .rd_wr_sel_i(rw), .addr_i(addr),
    .byte_write_en_n_i(bwn), .data_io_bus_i(bus),
    .data_io_bus_o(dout), .data_io_bus_oe_o(oe),
    .echo_clock_true_o(ect), .echo_clock_comp_o(ecc),
    .read_valid_flag_o(valid), .termination_ctrl_i(strap),
    .loop_off_n_i(loop_off_n), .dq_term_on_o(dterm),
    .bw_term_on_o(bw_term), .loop_locked_o(locked),
    .term_enabled_o(te_o), .imp_update_o(imp_upd));

  // ==========================================================
  // Compare and closing
  // ==========================================================
  task automatic chk_w(input string nm, input logic [35:0] e,
    input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk_w

  task automatic chk_b(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Lane merge for masked writes; enables are active low
  function automatic logic [35:0] mrg(input logic [35:0] o,
    input logic [35:0] n, input logic [3:0] e);
    mrg = o;
    for (int i = 0; i < 4; i++)
      if (!e[i]) mrg[i*9 +: 9] = n[i*9 +: 9];
  endfunction : mrg

  // ==========================================================
  // Read with latency, flag and termination checks
  // ==========================================================
  task automatic rd(input logic [3:0] a, input logic [35:0] e0,
    input logic [35:0] e1, input logic cd, input logic te);
    logic [35:0] q0;
    logic [35:0] q1;
    ctl_u.cmd(1'b1, a, '0, '0, '0, '0);
    // Load edge passed; word 0 leaves at the K fall two cycles on
    @(posedge k);
    #3 chk_b("term held", te, dterm);
    @(posedge k);
    #3 chk_b("term early", 1'b0, dterm);
    chk_b("oe early", 1'b0, oe);
    @(negedge k);
    #3 q0 = bus;
    chk_b("valid w0", 1'b1, valid);
    chk_b("oe w0", 1'b1, oe);
    chk_b("term w0", 1'b0, dterm);
    @(posedge k);
    #3 q1 = bus;
    chk_b("valid w1", 1'b1, valid);
    @(negedge k);
    #3 chk_b("oe after", 1'b0, oe);
    @(posedge k);
    #3 chk_b("term late", te, dterm);
    if (cd) begin
      chk_w("word0", e0, q0);
      chk_w("word1", e1, q1);
    end
  endtask : rd

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    #1 chk_b("lock wait", 1'b1, locked && n >= bsp_pkg::LOCK_CYC);
    chk_b("term strap", 1'b1, te_o);
    chk_b("bw term", 1'b1, bw_term);
    repeat (5) @(posedge k);
  endtask : t_power

  // Idle cycles between these carry hostile NOP address and enables
  task automatic t_rw();
    ctl_u.cmd(1'b0, 4'h3, A0, A1, '0, '0);
    ctl_u.cmd(1'b0, 4'hc, B0, B1, '0, '0);
    rd(4'h3, A0, A1, 1'b1, 1'b1);
    rd(4'hc, B0, B1, 1'b1, 1'b1);
  endtask : t_rw

  task automatic t_mask();
    ctl_u.cmd(1'b0, 4'h3, C0, C1, 4'ha, 4'h5);
    rd(4'h3, mrg(A0, C0, 4'ha), mrg(A1, C1, 4'h5), 1'b1, 1'b1);
    ctl_u.cmd(1'b0, 4'hc, C0, C1, 4'hf, 4'hf);
    rd(4'hc, B0, B1, 1'b1, 1'b1);
  endtask : t_mask

  task automatic t_echo();
    repeat (4) begin
      @(posedge k);
      #3 chk_b("echo true", 1'b1, ect);
      chk_b("echo comp", 1'b0, ecc);
      chk_b("idle oe", 1'b0, oe);
      @(negedge k);
      #3 chk_b("echo true", 1'b0, ect);
      chk_b("echo comp", 1'b1, ecc);
    end
  endtask : t_echo

  task automatic t_imp();
    int n;
    n = 0;
    while (imp_upd !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (imp_upd !== 1'b1 && n < 5000);
    chk_w("refresh gap", 36'(bsp_pkg::IMP_CYC), 36'(n));
  endtask : t_imp

  // New power-on with strap low and the loop bypassed
  task automatic t_restrap();
    @(posedge ref_clk);
    nrst <= 1'b0;
    strap <= 1'b0;
    loop_off_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (40) @(posedge ref_clk);
    #1 chk_b("lock bypass", 1'b1, locked);
    chk_b("term strap", 1'b0, te_o);
    chk_b("bw term", 1'b0, bw_term);
    repeat (5) @(posedge k);
    rd(4'h3, '0, '0, 1'b0, 1'b0);
  endtask : t_restrap

  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    t_power();
    t_rw();
    t_mask();
    t_echo();
    t_imp();
    t_restrap();
    results();
  end

  // Whole run needs about a third of this span
  initial begin
    #200000;
    n_errors++;
    results();
  end
endmodule : bsp_port_tb
`default_nettype wire
